// ### inc/dtc_map.svh
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// Register addresses
`define DTC_ADDR_RUNFLAG   8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_CNT0_LO   8'h8a
`define DTC_ADDR_CNT1_LO   8'h8b
`define DTC_ADDR_CNT0_HI   8'h8c
`define DTC_ADDR_CNT1_HI   8'h8d
`define DTC_ADDR_RATE      8'h8e
`define DTC_ADDR_IRQ_STAT  8'h9a
`define DTC_ADDR_IRQ_MASK  8'h9b

// Mode register fields
`define DTC_MODE_U1_GATE   7
`define DTC_MODE_U1_SRC    6
`define DTC_MODE_U1_MHI    5
`define DTC_MODE_U1_MLO    4
`define DTC_MODE_U0_GATE   3
`define DTC_MODE_U0_SRC    2
`define DTC_MODE_U0_MHI    1
`define DTC_MODE_U0_MLO    0

// Run and flag register fields
`define DTC_RF_OVF1        7
`define DTC_RF_RUN1        6
`define DTC_RF_OVF0        5
`define DTC_RF_RUN0        4

// Clock rate register fields
`define DTC_RATE_DIV1      4
`define DTC_RATE_DIV0      3

// Interrupt status and mask fields
`define DTC_IRQ_OVF0       0
`define DTC_IRQ_OVF1       1
`define DTC_IRQ_SPLIT      2
`define DTC_IRQ_MSB        2

// Synchronised pin vector positions
`define DTC_PIN_UNIT0_PIN_GATING      0
`define DTC_PIN_UNIT1_PIN_GATING      1
`define DTC_PIN_EVT0       2
`define DTC_PIN_EVT1       3
`define DTC_PIN_COUNT      4

// Reset values, widths, divisors
`define DTC_RST_BYTE       8'h00
`define DTC_RST_IRQ        3'h0
`define DTC_PRESCALE_MSB   4
`define DTC_DIV_FAST       4
`define DTC_DIV_SLOW       12
`define DTC_DIV_WIDTH      4

`endif

// ### inc/dtc_pkg.sv
package dtc_pkg;

  typedef logic [7:0] dtc_byte_t;

  typedef enum logic [1:0] {
    DTC_M13   = 2'h0,
    DTC_M16   = 2'h1,
    DTC_M8R   = 2'h2,
    DTC_SPLIT = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    dtc_byte_t lo;
    dtc_byte_t hi;
    logic      ovf;
  } dtc_cnt_t;

endpackage

// ### rtl/dtc_prescale.sv
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_prescale #(
  parameter logic [`DTC_DIV_WIDTH-1:0] FAST_DIV = `DTC_DIV_WIDTH'(`DTC_DIV_FAST),
  parameter logic [`DTC_DIV_WIDTH-1:0] SLOW_DIV = `DTC_DIV_WIDTH'(`DTC_DIV_SLOW)
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick_fast,
  output logic      tick_slow
);

  logic [`DTC_DIV_WIDTH-1:0] fast_q;
  logic [`DTC_DIV_WIDTH-1:0] slow_q;
  logic                      fast_end;
  logic                      slow_end;

  function automatic logic [`DTC_DIV_WIDTH-1:0] wrap(input logic [`DTC_DIV_WIDTH-1:0] c,
                                                    input logic                      last);
    wrap = last ? '0 : c + 1'b1;
  endfunction

  assign fast_end = (fast_q == FAST_DIV - 1'b1);
  assign slow_end = (slow_q == SLOW_DIV - 1'b1);

  // One-cycle enables at clock/4 and clock/12
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_q    <= '0;
      slow_q    <= '0;
      tick_fast <= 1'b0;
      tick_slow <= 1'b0;
    end else begin
      fast_q    <= wrap(fast_q, fast_end);
      slow_q    <= wrap(slow_q, slow_end);
      tick_fast <= fast_end;
      tick_slow <= slow_end;
    end
  end

endmodule

// ### rtl/dtc_pin_sync.sv
`timescale 1ns/1ps

module dtc_pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] prev_q;

  // Two flops, then a third for falling edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      level  <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      level  <= meta_q;
      prev_q <= level;
    end
  end

  assign fall = prev_q & ~level;

endmodule

// ### rtl/dtc_top.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_top
  import dtc_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              SYS_RST,
  input  wire dtc_pkg::dtc_byte_t ADDR,
  input  wire dtc_pkg::dtc_byte_t WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output dtc_pkg::dtc_byte_t     RDATA,
  input  wire logic              EXT_IRQ0_PIN,
  input  wire logic              EXT_IRQ1_PIN,
  input  wire logic              UNIT0_EVENT_PIN,
  input  wire logic              UNIT1_EVENT_PIN,
  input  wire logic              UNIT0_VECTOR_ACK,
  input  wire logic              UNIT1_VECTOR_ACK,
  output logic                   UNIT0_OVERFLOW_FLAG,
  output logic                   UNIT1_OVERFLOW_FLAG,
  output logic                   IRQ
);

  // Registers
  dtc_byte_t                timer_mode_control_q;
  dtc_byte_t                count0_low_byte_q;
  dtc_byte_t                count0_high_byte_q;
  dtc_byte_t                count1_low_byte_q;
  dtc_byte_t                count1_high_byte_q;
  logic                     unit0_run_q;
  logic                     unit1_run_q;
  logic                     unit0_overflow_flag_q;
  logic                     unit1_overflow_flag_q;
  logic                     unit0_divisor_select_q;
  logic                     unit1_divisor_select_q;
  logic [`DTC_IRQ_MSB:0]    irq_stat_q;
  logic [`DTC_IRQ_MSB:0]    irq_mask_q;
  dtc_byte_t                rdata_q;
  logic                     irq_q;

  // Next values
  dtc_byte_t                count0_low_byte_d;
  dtc_byte_t                count0_high_byte_d;
  dtc_byte_t                count1_low_byte_d;
  dtc_byte_t                count1_high_byte_d;
  logic                     unit0_overflow_flag_d;
  logic                     unit1_overflow_flag_d;
  logic [`DTC_IRQ_MSB:0]    irq_stat_d;
  logic [`DTC_IRQ_MSB:0]    irq_mask_d;
  dtc_byte_t                rdata_d;

  // Pins and prescaler
  logic [`DTC_PIN_COUNT-1:0] pin_raw;
  logic [`DTC_PIN_COUNT-1:0] pin_level;
  logic [`DTC_PIN_COUNT-1:0] pin_fall;
  logic                      tick_fast;
  logic                      tick_slow;

  // Decoded controls
  logic                     unit0_pin_gating;
  logic                     unit1_pin_gating;
  logic                     unit0_source_select;
  logic                     unit1_source_select;
  dtc_mode_t                unit0_mode;
  dtc_mode_t                unit1_mode;
  logic                     unit0_time_tick;
  logic                     unit1_time_tick;
  logic                     unit0_gate_open;
  logic                     unit1_gate_open;
  logic                     unit0_adv;
  logic                     unit1_adv;
  logic                     split_hi_adv;
  logic                     unit1_stopped;

  // Counting results
  dtc_cnt_t                 unit0_next;
  dtc_cnt_t                 unit1_next;
  logic [8:0]               split_hi_next;
  logic                     unit0_ovf_evt;
  logic                     unit1_ovf_evt;
  logic                     split_ovf_evt;
  logic                     ovf1_set;

  // Bus decode
  logic                     wr_runflag;
  logic                     wr_mode;
  logic                     wr_c0_lo;
  logic                     wr_c0_hi;
  logic                     wr_c1_lo;
  logic                     wr_c1_hi;
  logic                     wr_rate;
  logic                     wr_stat;
  logic                     wr_mask;
  dtc_byte_t                runflag_view;
  dtc_byte_t                rate_view;
  logic [`DTC_IRQ_MSB:0]    irq_events;

  // Byte increment with carry out in the top bit
  function automatic logic [8:0] inc8(input dtc_byte_t b);
    inc8 = {&b, b + 8'h01};
  endfunction

  // Register select by address
  function automatic logic sel(input dtc_byte_t a, input dtc_byte_t want, input logic stb);
    sel = stb && (a == want);
  endfunction

  // One counting step of a unit in the given mode
  function automatic dtc_cnt_t cnt_step(input dtc_mode_t m,
                                       input dtc_byte_t lo,
                                       input dtc_byte_t hi);
    dtc_cnt_t                   r;
    logic [`DTC_PRESCALE_MSB:0] pre;
    logic [8:0]                 t;
    r   = '{lo: lo, hi: hi, ovf: 1'b0};
    pre = lo[`DTC_PRESCALE_MSB:0];
    t   = inc8(lo);
    case (m)
      DTC_M13: begin
        r.lo[`DTC_PRESCALE_MSB:0] = pre + 1'b1;
        if (&pre) begin
          t     = inc8(hi);
          r.hi  = t[7:0];
          r.ovf = t[8];
        end
      end
      DTC_M16: begin
        r.lo  = t[7:0];
        if (t[8]) begin
          t     = inc8(hi);
          r.hi  = t[7:0];
          r.ovf = t[8];
        end
      end
      DTC_M8R: begin
        r.lo  = t[8] ? hi : t[7:0];
        r.ovf = t[8];
      end
      default: begin
        r.lo  = t[7:0];
        r.ovf = t[8];
      end
    endcase
    return r;
  endfunction

  assign pin_raw[`DTC_PIN_UNIT0_PIN_GATING] = EXT_IRQ0_PIN;
  assign pin_raw[`DTC_PIN_UNIT1_PIN_GATING] = EXT_IRQ1_PIN;
  assign pin_raw[`DTC_PIN_EVT0]  = UNIT0_EVENT_PIN;
  assign pin_raw[`DTC_PIN_EVT1]  = UNIT1_EVENT_PIN;

  dtc_pin_sync #(
    .WIDTH (`DTC_PIN_COUNT)
  ) u_sync (
    .clk   (CLOCK),
    .rst   (SYS_RST),
    .pin   (pin_raw),
    .level (pin_level),
    .fall  (pin_fall)
  );

  dtc_prescale #(
    .FAST_DIV (`DTC_DIV_WIDTH'(`DTC_DIV_FAST)),
    .SLOW_DIV (`DTC_DIV_WIDTH'(`DTC_DIV_SLOW))
  ) u_pre (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .tick_fast (tick_fast),
    .tick_slow (tick_slow)
  );

  // Mode register fields
  assign unit1_pin_gating    = timer_mode_control_q[`DTC_MODE_U1_GATE];
  assign unit1_source_select = timer_mode_control_q[`DTC_MODE_U1_SRC];
  assign unit1_mode          = dtc_mode_t'({timer_mode_control_q[`DTC_MODE_U1_MHI],
                                            timer_mode_control_q[`DTC_MODE_U1_MLO]});
  assign unit0_pin_gating    = timer_mode_control_q[`DTC_MODE_U0_GATE];
  assign unit0_source_select = timer_mode_control_q[`DTC_MODE_U0_SRC];
  assign unit0_mode          = dtc_mode_t'({timer_mode_control_q[`DTC_MODE_U0_MHI],
                                            timer_mode_control_q[`DTC_MODE_U0_MLO]});

  // Time base per unit
  assign unit0_time_tick = unit0_divisor_select_q ? tick_fast : tick_slow;
  assign unit1_time_tick = unit1_divisor_select_q ? tick_fast : tick_slow;

  // Gating by run bit and optional pin level
  assign unit0_gate_open = unit0_run_q &&
                           (!unit0_pin_gating || pin_level[`DTC_PIN_UNIT0_PIN_GATING]);
  assign unit1_gate_open = unit1_run_q &&
                           (!unit1_pin_gating || pin_level[`DTC_PIN_UNIT1_PIN_GATING]);
  assign unit1_stopped   = (unit1_mode == DTC_SPLIT);

  // Advance enables; divisor select ignored when counting pin events
  assign unit0_adv = unit0_gate_open &&
                     (unit0_source_select ? pin_fall[`DTC_PIN_EVT0] : unit0_time_tick);
  assign unit1_adv = unit1_gate_open && !unit1_stopped &&
                     (unit1_source_select ? pin_fall[`DTC_PIN_EVT1] : unit1_time_tick);
  // Split mode high byte: timer only, run by unit 1's run bit
  assign split_hi_adv = (unit0_mode == DTC_SPLIT) && unit1_run_q && unit0_time_tick;

  // Independent count steps for each unit
  assign unit0_next    = cnt_step(unit0_mode, count0_low_byte_q, count0_high_byte_q);
  assign unit1_next    = cnt_step(unit1_mode, count1_low_byte_q, count1_high_byte_q);
  assign split_hi_next = inc8(count0_high_byte_q);

  assign unit0_ovf_evt = unit0_adv && unit0_next.ovf;
  assign unit1_ovf_evt = unit1_adv && unit1_next.ovf;
  assign split_ovf_evt = split_hi_adv && split_hi_next[8];
  assign ovf1_set      = unit1_ovf_evt || split_ovf_evt;

  // Bus write decode
  assign wr_runflag = sel(ADDR, `DTC_ADDR_RUNFLAG, WR_STB);
  assign wr_mode    = sel(ADDR, `DTC_ADDR_MODE, WR_STB);
  assign wr_c0_lo   = sel(ADDR, `DTC_ADDR_CNT0_LO, WR_STB);
  assign wr_c0_hi   = sel(ADDR, `DTC_ADDR_CNT0_HI, WR_STB);
  assign wr_c1_lo   = sel(ADDR, `DTC_ADDR_CNT1_LO, WR_STB);
  assign wr_c1_hi   = sel(ADDR, `DTC_ADDR_CNT1_HI, WR_STB);
  assign wr_rate    = sel(ADDR, `DTC_ADDR_RATE, WR_STB);
  assign wr_stat    = sel(ADDR, `DTC_ADDR_IRQ_STAT, WR_STB);
  assign wr_mask    = sel(ADDR, `DTC_ADDR_IRQ_MASK, WR_STB);

  // Count bytes: a software write to a byte wins over counting of that byte
  assign count0_low_byte_d  = wr_c0_lo ? WDATA :
                              unit0_adv ? unit0_next.lo : count0_low_byte_q;
  assign count0_high_byte_d = wr_c0_hi ? WDATA :
                              split_hi_adv ? split_hi_next[7:0] :
                              (unit0_adv && unit0_mode != DTC_SPLIT) ? unit0_next.hi :
                              count0_high_byte_q;
  assign count1_low_byte_d  = wr_c1_lo ? WDATA :
                              unit1_adv ? unit1_next.lo : count1_low_byte_q;
  assign count1_high_byte_d = wr_c1_hi ? WDATA :
                              unit1_adv ? unit1_next.hi : count1_high_byte_q;

  // Overflow flags: hardware set wins over acknowledge or software clear
  assign unit0_overflow_flag_d =
    unit0_ovf_evt ||
    (wr_runflag ? WDATA[`DTC_RF_OVF0] :
     (unit0_overflow_flag_q && !UNIT0_VECTOR_ACK));
  assign unit1_overflow_flag_d =
    ovf1_set ||
    (wr_runflag ? WDATA[`DTC_RF_OVF1] :
     (unit1_overflow_flag_q && !UNIT1_VECTOR_ACK));

  // Sticky interrupt status, write one to clear, set wins
  assign irq_events[`DTC_IRQ_OVF0]  = unit0_ovf_evt;
  assign irq_events[`DTC_IRQ_OVF1]  = unit1_ovf_evt;
  assign irq_events[`DTC_IRQ_SPLIT] = split_ovf_evt;
  assign irq_stat_d = irq_events |
                      (irq_stat_q & ~(wr_stat ? WDATA[`DTC_IRQ_MSB:0] : `DTC_RST_IRQ));
  // Mask change reaches the interrupt pin at its write edge, as status does
  assign irq_mask_d = wr_mask ? WDATA[`DTC_IRQ_MSB:0] : irq_mask_q;

  // Read views
  assign runflag_view = {unit1_overflow_flag_q, unit1_run_q,
                         unit0_overflow_flag_q, unit0_run_q, 4'h0};
  assign rate_view    = {3'h0, unit1_divisor_select_q, unit0_divisor_select_q, 3'h0};

  always_comb begin
    rdata_d = `DTC_RST_BYTE;
    if (RD_STB) begin
      case (ADDR)
        `DTC_ADDR_RUNFLAG:  rdata_d = runflag_view;
        `DTC_ADDR_MODE:     rdata_d = timer_mode_control_q;
        `DTC_ADDR_CNT0_LO:  rdata_d = count0_low_byte_q;
        `DTC_ADDR_CNT1_LO:  rdata_d = count1_low_byte_q;
        `DTC_ADDR_CNT0_HI:  rdata_d = count0_high_byte_q;
        `DTC_ADDR_CNT1_HI:  rdata_d = count1_high_byte_q;
        `DTC_ADDR_RATE:     rdata_d = rate_view;
        `DTC_ADDR_IRQ_STAT: rdata_d = {5'h00, irq_stat_q};
        `DTC_ADDR_IRQ_MASK: rdata_d = {5'h00, irq_mask_q};
        default:            rdata_d = `DTC_RST_BYTE;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      timer_mode_control_q   <= `DTC_RST_BYTE;
      unit0_run_q            <= 1'b0;
      unit1_run_q            <= 1'b0;
      unit0_divisor_select_q <= 1'b0;
      unit1_divisor_select_q <= 1'b0;
      irq_mask_q             <= `DTC_RST_IRQ;
    end else begin
      if (wr_mode) begin
        timer_mode_control_q <= WDATA;
      end
      if (wr_runflag) begin
        unit0_run_q <= WDATA[`DTC_RF_RUN0];
        unit1_run_q <= WDATA[`DTC_RF_RUN1];
      end
      if (wr_rate) begin
        unit0_divisor_select_q <= WDATA[`DTC_RATE_DIV0];
        unit1_divisor_select_q <= WDATA[`DTC_RATE_DIV1];
      end
      if (wr_mask) begin
        irq_mask_q <= WDATA[`DTC_IRQ_MSB:0];
      end
    end
  end

  // Counter bytes and flags
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      count0_low_byte_q     <= `DTC_RST_BYTE;
      count0_high_byte_q    <= `DTC_RST_BYTE;
      count1_low_byte_q     <= `DTC_RST_BYTE;
      count1_high_byte_q    <= `DTC_RST_BYTE;
      unit0_overflow_flag_q <= 1'b0;
      unit1_overflow_flag_q <= 1'b0;
      irq_stat_q            <= `DTC_RST_IRQ;
    end else begin
      count0_low_byte_q     <= count0_low_byte_d;
      count0_high_byte_q    <= count0_high_byte_d;
      count1_low_byte_q     <= count1_low_byte_d;
      count1_high_byte_q    <= count1_high_byte_d;
      unit0_overflow_flag_q <= unit0_overflow_flag_d;
      unit1_overflow_flag_q <= unit1_overflow_flag_d;
      irq_stat_q            <= irq_stat_d;
    end
  end

  // Registered outputs
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q             <= `DTC_RST_BYTE;
      irq_q               <= 1'b0;
      UNIT0_OVERFLOW_FLAG <= 1'b0;
      UNIT1_OVERFLOW_FLAG <= 1'b0;
    end else begin
      rdata_q             <= rdata_d;
      irq_q               <= |(irq_stat_d & irq_mask_d);
      UNIT0_OVERFLOW_FLAG <= unit0_overflow_flag_d;
      UNIT1_OVERFLOW_FLAG <= unit1_overflow_flag_d;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ   = irq_q;

endmodule

// ### bench/dtc_top_assertions.sv
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_top_assertions
  import dtc_pkg::*;
(
  input wire logic               CLOCK,
  input wire logic               SYS_RST,
  input wire dtc_pkg::dtc_byte_t ADDR,
  input wire dtc_pkg::dtc_byte_t WDATA,
  input wire logic               WR_STB,
  input wire logic               RD_STB,
  input wire dtc_pkg::dtc_byte_t RDATA,
  input wire logic               EXT_IRQ0_PIN,
  input wire logic               EXT_IRQ1_PIN,
  input wire logic               UNIT0_EVENT_PIN,
  input wire logic               UNIT1_EVENT_PIN,
  input wire logic               UNIT0_VECTOR_ACK,
  input wire logic               UNIT1_VECTOR_ACK,
  input wire logic               UNIT0_OVERFLOW_FLAG,
  input wire logic               UNIT1_OVERFLOW_FLAG,
  input wire logic               IRQ
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_mode_wr;
    WR_STB && ADDR == `DTC_ADDR_MODE;
  endsequence
  sequence s_mode_rd;
    RD_STB && ADDR == `DTC_ADDR_MODE;
  endsequence

  a_rdata_idle_zero: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
    else $error("read data not zero outside read cycle");
  a_mode_read_back: assert property (
    s_mode_wr ##1 !WR_STB ##1 s_mode_rd |=> RDATA == $past(WDATA, 3))
    else $error("mode register read back differs");
  a_unmapped_read_zero: assert property (
    RD_STB && ADDR == 8'h80 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_flag0_fall_cause: assert property ($fell(UNIT0_OVERFLOW_FLAG) |->
    $past(UNIT0_VECTOR_ACK) || $past(WR_STB && ADDR == `DTC_ADDR_RUNFLAG))
    else $error("flag 0 cleared without cause");
  a_flag1_fall_cause: assert property ($fell(UNIT1_OVERFLOW_FLAG) |->
    $past(UNIT1_VECTOR_ACK) || $past(WR_STB && ADDR == `DTC_ADDR_RUNFLAG))
    else $error("flag 1 cleared without cause");
  a_flag0_write_set: assert property (
    WR_STB && ADDR == `DTC_ADDR_RUNFLAG && WDATA[`DTC_RF_OVF0] |=> UNIT0_OVERFLOW_FLAG)
    else $error("flag 0 not set by write");
  a_flag1_write_set: assert property (
    WR_STB && ADDR == `DTC_ADDR_RUNFLAG && WDATA[`DTC_RF_OVF1] |=> UNIT1_OVERFLOW_FLAG)
    else $error("flag 1 not set by write");
  a_irq_rise_cause: assert property ($rose(IRQ) |-> UNIT0_OVERFLOW_FLAG ||
    UNIT1_OVERFLOW_FLAG || $past(WR_STB && ADDR == `DTC_ADDR_IRQ_MASK))
    else $error("interrupt raised without cause");
  a_irq_fall_write: assert property ($fell(IRQ) |-> $past(WR_STB))
    else $error("interrupt dropped without write");
endmodule

bind dtc_top dtc_top_assertions u_chk (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .EXT_IRQ0_PIN(EXT_IRQ0_PIN), .EXT_IRQ1_PIN(EXT_IRQ1_PIN),
  .UNIT0_EVENT_PIN(UNIT0_EVENT_PIN), .UNIT1_EVENT_PIN(UNIT1_EVENT_PIN),
  .UNIT0_VECTOR_ACK(UNIT0_VECTOR_ACK), .UNIT1_VECTOR_ACK(UNIT1_VECTOR_ACK),
  .UNIT0_OVERFLOW_FLAG(UNIT0_OVERFLOW_FLAG),
  .UNIT1_OVERFLOW_FLAG(UNIT1_OVERFLOW_FLAG), .IRQ(IRQ)
);

// ### bench/dtc_partner.sv
`timescale 1ns/1ps

module dtc_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] evt_go,
  input  wire logic [1:0] ack_en,
  input  wire logic [1:0] flag,
  output logic      [1:0] evt_pin,
  output logic      [1:0] ack
);
  logic [3:0] cnt_q [2];

  // Event pin idles high, one low pulse per request
  assign evt_pin[0] = !(cnt_q[0] > 4'h4);
  assign evt_pin[1] = !(cnt_q[1] > 4'h4);

  always_ff @(posedge clk) begin
    ack <= rst ? 2'h0 : ack_en & flag & ~ack;
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        cnt_q[i] <= 4'h0;
      end else if (evt_go[i]) begin
        cnt_q[i] <= 4'h8;
      end else if (cnt_q[i] != 4'h0) begin
        cnt_q[i] <= cnt_q[i] - 4'h1;
      end
    end
  end
endmodule

// ### bench/dtc_top_tb.sv
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_top_tb;
  import dtc_pkg::*;
  logic       CLOCK;
  logic       SYS_RST;
  dtc_byte_t  ADDR;
  dtc_byte_t  WDATA;
  logic       WR_STB;
  logic       RD_STB;
  dtc_byte_t  RDATA;
  logic       EXT_IRQ0_PIN;
  logic       EXT_IRQ1_PIN;
  logic       IRQ;
  logic [1:0] evt_go;
  logic [1:0] ack_en;
  logic [1:0] evt_pin;
  logic [1:0] ack;
  logic [1:0] flag;
  int         fail_count;
  int         n_checks;
  int         n;
  dtc_byte_t  regs [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e,
                            8'h9a, 8'h9b, 8'h80};

  dtc_top dut (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .EXT_IRQ0_PIN(EXT_IRQ0_PIN), .EXT_IRQ1_PIN(EXT_IRQ1_PIN),
    .UNIT0_EVENT_PIN(evt_pin[0]), .UNIT1_EVENT_PIN(evt_pin[1]),
    .UNIT0_VECTOR_ACK(ack[0]), .UNIT1_VECTOR_ACK(ack[1]),
    .UNIT0_OVERFLOW_FLAG(flag[0]), .UNIT1_OVERFLOW_FLAG(flag[1]), .IRQ(IRQ)
  );

  dtc_partner u_core (
    .clk(CLOCK), .rst(SYS_RST), .evt_go(evt_go), .ack_en(ack_en),
    .flag(flag), .evt_pin(evt_pin), .ack(ack)
  );

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input dtc_byte_t exp, input dtc_byte_t got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input dtc_byte_t a, input dtc_byte_t d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string name, input dtc_byte_t a, input dtc_byte_t exp);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    #1;
    chk(name, exp, RDATA);
  endtask

  task automatic wait_flag(input int u, input int bound);
    n = 0;
    while (flag[u] !== 1'b1) begin
      if (n >= bound) begin
        fail_count++;
        $display("FAIL overflow flag expected 1 seen %b", flag[u]);
        finish_test();
      end
      @(posedge CLOCK);
      #1;
      n++;
    end
  endtask

  // Count to overflow on unit 0 bytes, stop, then read both bytes
  task automatic run_case(input string name, input int u, input dtc_byte_t mode, rate,
                          lo, hi, run, elo, ehi, input int minn, bound);
    wr(`DTC_ADDR_IRQ_STAT, 8'h07);
    wr(`DTC_ADDR_MODE, mode);
    wr(`DTC_ADDR_RATE, rate);
    wr(`DTC_ADDR_CNT0_LO, lo);
    wr(`DTC_ADDR_CNT0_HI, hi);
    wr(`DTC_ADDR_RUNFLAG, run);
    wait_flag(u, bound);
    wr(`DTC_ADDR_RUNFLAG, 8'h00);
    chk("ticks", 8'h01, dtc_byte_t'(n >= minn));
    rdchk("low", `DTC_ADDR_CNT0_LO, elo);
    rdchk("high", `DTC_ADDR_CNT0_HI, ehi);
    $display("test %s done", name);
  endtask

  // Run for a while with event pulses, then read the low byte
  task automatic cnt_case(input string name, input int u, input dtc_byte_t mode, run,
                          a, start, exp, input int pulses);
    wr(`DTC_ADDR_MODE, mode);
    wr(`DTC_ADDR_RATE, 8'h18);
    wr(a, start);
    wr(`DTC_ADDR_RUNFLAG, run);
    repeat (pulses) begin
      @(posedge CLOCK);
      evt_go[u] <= 1'b1;
      @(posedge CLOCK);
      evt_go[u] <= 1'b0;
      repeat (10) @(posedge CLOCK);
    end
    repeat (40) @(posedge CLOCK);
    wr(`DTC_ADDR_RUNFLAG, 8'h00);
    rdchk(name, a, exp);
    $display("test %s done", name);
  endtask

  initial begin
    SYS_RST = 1'b1;
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    EXT_IRQ0_PIN = 1'b0;
    EXT_IRQ1_PIN = 1'b0;
    evt_go = 2'h0;
    ack_en = 2'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    foreach (regs[i]) rdchk("reset", regs[i], 8'h00);
    wr(8'h80, 8'hff);
    rdchk("unmapped", 8'h80, 8'h00);
    wr(`DTC_ADDR_MODE, 8'ha5);
    rdchk("mode", `DTC_ADDR_MODE, 8'ha5);
    wr(`DTC_ADDR_IRQ_MASK, 8'h01);
    run_case("m16", 0, 8'h01, 8'h08, 8'hfc, 8'hff, 8'h10, 8'h00, 8'h00, 9, 20);
    rdchk("status", `DTC_ADDR_IRQ_STAT, 8'h01);
    chk("irq set", 8'h01, {7'h0, IRQ});
    wr(`DTC_ADDR_IRQ_MASK, 8'h00);
    chk("irq masked", 8'h00, {7'h0, IRQ});
    wr(`DTC_ADDR_IRQ_MASK, 8'h01);
    chk("irq unmasked", 8'h01, {7'h0, IRQ});
    wr(`DTC_ADDR_IRQ_STAT, 8'h01);
    chk("irq cleared", 8'h00, {7'h0, IRQ});
    wr(`DTC_ADDR_RUNFLAG, 8'ha0);
    chk("flags set", 8'h03, {6'h0, flag});
    ack_en <= 2'h3;
    repeat (4) @(posedge CLOCK);
    #1;
    chk("flags acked", 8'h00, {6'h0, flag});
    run_case("m13", 0, 8'h00, 8'h00, 8'hfe, 8'hff, 8'h10, 8'he0, 8'h00, 10, 40);
    run_case("m8r", 0, 8'h02, 8'h00, 8'hfe, 8'h80, 8'h10, 8'h80, 8'h80, 10, 40);
    run_case("split", 1, 8'h03, 8'h08, 8'h00, 8'hff, 8'h50, 8'h01, 8'h00, 0, 20);
    cnt_case("hold1", 1, 8'h30, 8'h40, `DTC_ADDR_CNT1_LO, 8'h12, 8'h12, 0);
    cnt_case("norun", 0, 8'h01, 8'h00, `DTC_ADDR_CNT0_LO, 8'h12, 8'h12, 0);
    cnt_case("gate0lo", 0, 8'h0d, 8'h10, `DTC_ADDR_CNT0_LO, 8'h00, 8'h00, 2);
    @(posedge CLOCK);
    EXT_IRQ0_PIN <= 1'b1;
    cnt_case("gate0hi", 0, 8'h0d, 8'h10, `DTC_ADDR_CNT0_LO, 8'h00, 8'h02, 2);
    cnt_case("gate1lo", 1, 8'hd0, 8'h40, `DTC_ADDR_CNT1_LO, 8'h00, 8'h00, 2);
    @(posedge CLOCK);
    EXT_IRQ1_PIN <= 1'b1;
    cnt_case("gate1hi", 1, 8'hd0, 8'h40, `DTC_ADDR_CNT1_LO, 8'h00, 8'h02, 2);
    cnt_case("evtdiv", 1, 8'h50, 8'h40, `DTC_ADDR_CNT1_LO, 8'h07, 8'h07, 0);
    finish_test();
  end
endmodule
